// [pkg/flr_pkg.sv]
// How it works
// - Local ramp field sets local fan slew limit.
// - Fast ramp codes step 1 to 48.
// - Slow select stretches every sweep time.
// - Bit 3 enables local channel smoothing.
// - Bits 6:4 set remote two slew limit.
// - Bit 7 enables remote two smoothing.
// - Floor duty maps linearly, 0x00 off, 0xff full.
// - Floors are read-only in automatic mode.
// - Lock bit makes all loop registers read-only.
// - Above start temperature fan rises from floor.
// - Start temperatures at 0x67..0x69, reset 0x5a.
// - Any critical excess forces all fans full.
// - Critical limit 0x80 disables the fail-safe.
// - Full duty holds until below limit minus hysteresis.
// - Quarter degree excess drives overtemperature pin low.
// - Critical limits at 0x6a..0x6c, reset 0x64.
// - Hysteresis registers 0x6d, 0x6e reset 0x44.
// - Register 0x6d holds two nibble fields; 0x6e uses only its high nibble.
// - Below start, floor holds until start minus hysteresis.
// - Below that, hold bit picks floor or off.
// - Quarter-rate bits slow ramp four times more.
package flr_pkg;

  localparam logic [7:0] ADDR_ACOUSTIC2  = 8'h63;
  localparam logic [7:0] ADDR_FLOOR1     = 8'h64;
  localparam logic [7:0] ADDR_FLOOR2     = 8'h65;
  localparam logic [7:0] ADDR_FLOOR3     = 8'h66;
  localparam logic [7:0] ADDR_START_R1   = 8'h67;
  localparam logic [7:0] ADDR_START_LOC  = 8'h68;
  localparam logic [7:0] ADDR_START_R2   = 8'h69;
  localparam logic [7:0] ADDR_CRIT_R1    = 8'h6a;
  localparam logic [7:0] ADDR_CRIT_LOC   = 8'h6b;
  localparam logic [7:0] ADDR_CRIT_R2    = 8'h6c;
  localparam logic [7:0] ADDR_HYST_R1LOC = 8'h6d;
  localparam logic [7:0] ADDR_HYST_CPUR2 = 8'h6e;

  localparam logic [7:0] RST_ACOUSTIC2 = 8'h00;
  localparam logic [7:0] RST_FLOOR     = 8'h80;
  localparam logic [7:0] RST_START     = 8'h5a;
  localparam logic [7:0] RST_CRIT      = 8'h64;
  localparam logic [7:0] RST_HYST      = 8'h44;
  localparam logic [7:0] CRIT_DISABLE  = 8'h80;
  localparam logic [7:0] DUTY_FULL     = 8'hff;
  localparam logic [7:0] DUTY_OFF      = 8'h00;

  localparam int LOCAL_RATE_LSB   = 0;
  localparam int LOCAL_SMOOTH_BIT = 3;
  localparam int R2_RATE_LSB      = 4;
  localparam int R2_SMOOTH_BIT    = 7;
  localparam int HYST_LO_LSB      = 0;
  localparam int HYST_HI_LSB      = 4;
  localparam int TEMP_FRAC        = 2;

  localparam longint CLK_HZ        = 125000000;
  localparam longint SWEEP_FAST_DS = 375;
  localparam longint SWEEP_SLOW_DS = 522;
  localparam longint DS_PER_S      = 10;
  localparam longint DUTY_STEPS    = 255;
  localparam int unsigned TICK_FAST_CYCLES = 32'(SWEEP_FAST_DS * CLK_HZ / DS_PER_S / DUTY_STEPS);
  localparam int unsigned TICK_SLOW_CYCLES = 32'(SWEEP_SLOW_DS * CLK_HZ / DS_PER_S / DUTY_STEPS);
  localparam int unsigned QUARTER_FACTOR   = 4;
  localparam logic [1:0] RST_SYNC = 2'b00;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;

  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    logic [7:0] step;
    step = 8'h01;
    unique case (code)
      3'h0: step = 8'h01;
      3'h1: step = 8'h02;
      3'h2: step = 8'h03;
      3'h3: step = 8'h04;
      3'h4: step = 8'h08;
      3'h5: step = 8'h0c;
      3'h6: step = 8'h18;
      3'h7: step = 8'h30;
    endcase
    return step;
  endfunction

  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? 8'(a - b) : 8'h00;
  endfunction

endpackage

// [verilog/flr_ramp.sv]
`timescale 1ns/10ps
`default_nettype none
module flr_ramp #(
  parameter int unsigned TICK_FAST = flr_pkg::TICK_FAST_CYCLES,
  parameter int unsigned TICK_SLOW = flr_pkg::TICK_SLOW_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       smooth_en,
  input  wire logic [2:0] rate_code,
  input  wire logic       slow_select,
  input  wire logic       quarter_rate,
  input  wire logic [7:0] target,
  // Result
  output logic      [7:0] duty
);

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic [7:0]  duty;
  } flr_ramp_s;

  flr_ramp_s   s;
  flr_ramp_s   n;
  logic [31:0] period;
  logic        tick;
  logic [7:0]  step;

  generate
    if (TICK_FAST < 1 || TICK_SLOW < 1 || TICK_SLOW > 32'h3fff_ffff) begin : g_bad
      $error("flr_ramp tick periods out of range");
    end
  endgenerate

  always_comb begin
    n      = s;
    period = slow_select ? TICK_SLOW : TICK_FAST;
    if (quarter_rate) begin
      period = 32'(period * flr_pkg::QUARTER_FACTOR);
    end
    step = flr_pkg::ramp_step(rate_code);
    tick = (s.tick_cnt >= 32'(period - 1));
    n.tick_cnt = tick ? flr_pkg::CNT_ZERO : 32'(s.tick_cnt + 1);
    if (!smooth_en) begin
      n.duty = target;
    end else if (tick) begin
      if (s.duty < target) begin
        n.duty = (8'(target - s.duty) > step) ? 8'(s.duty + step) : target;
      end else if (s.duty > target) begin
        n.duty = (8'(s.duty - target) > step) ? 8'(s.duty - step) : target;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.tick_cnt <= flr_pkg::CNT_ZERO;
      s.duty     <= flr_pkg::DUTY_FULL;
    end else begin
      s <= n;
    end
  end

  assign duty = s.duty;

  AST_RAMP_BYPASS: assert property (@(posedge clk) disable iff (!rst_n)
    !smooth_en |=> duty == $past(target))
    else $error("ramp bypass did not follow target");

  AST_RAMP_SLEW: assert property (@(posedge clk) disable iff (!rst_n)
    smooth_en |=> ((duty >= $past(duty)) ? 8'(duty - $past(duty)) : 8'($past(duty) - duty))
                  <= flr_pkg::ramp_step($past(rate_code)))
    else $error("ramp step larger than selected rate");

  AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (smooth_en && !tick) |=> $stable(duty))
    else $error("ramp moved between ticks");

  AST_RAMP_PERIOD: assert property (@(posedge clk) disable iff (!rst_n)
    (quarter_rate && slow_select && tick) |-> s.tick_cnt >= 32'(TICK_SLOW * 4 - 1))
    else $error("quarter rate tick came early");

endmodule
`default_nettype wire

// [verilog/flr_fan_loop.sv]
`timescale 1ns/10ps
`default_nettype none
module flr_fan_loop #(
  parameter int unsigned TICK_FAST = flr_pkg::TICK_FAST_CYCLES,
  parameter int unsigned TICK_SLOW = flr_pkg::TICK_SLOW_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register port from the serial management logic
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rd_addr,
  output logic      [7:0] reg_rdata,
  // Mode and configuration bits held elsewhere
  input  wire logic       config_lock,
  input  wire logic       auto_mode,
  input  wire logic       ramp_slow_select,
  input  wire logic       local_quarter_rate,
  input  wire logic       remote2_quarter_rate,
  input  wire logic       fan1_below_start_hold,
  input  wire logic       fan2_below_start_hold,
  input  wire logic       fan3_below_start_hold,
  input  wire logic       overtemp_pin_is_output,
  // Measured temperatures, whole degrees above two fraction bits
  input  wire logic [9:0] remote1_temp,
  input  wire logic [9:0] local_temp,
  input  wire logic [9:0] remote2_temp,
  // Duty rise per degree above start, from the range logic
  input  wire logic [7:0] remote1_ramp_temperature_span,
  input  wire logic [7:0] local_ramp_temperature_span,
  input  wire logic [7:0] remote2_ramp_temperature_span,
  // Fan drive and protection
  output logic      [7:0] fan1_duty,
  output logic      [7:0] fan2_duty,
  output logic      [7:0] fan3_duty,
  output logic            failsafe_active,
  output logic            overtemp_signal_o,
  output logic            overtemp_signal_oe_n
);

  typedef struct packed {
    logic [7:0]      acoustic;
    logic [2:0][7:0] floor_duty;
    logic [2:0][7:0] start;
    logic [2:0][7:0] crit;
    logic [7:0]      hyst_r1loc;
    logic [7:0]      hyst_cpur2;
    logic [2:0]      running;
    logic [2:0]      crit_on;
    logic [2:0][7:0] target;
    logic [2:0][7:0] fan_out;
    logic            failsafe;
    logic            ot_drive;
    logic            ot_level;
    logic [7:0]      rdata;
  } flr_loop_s;

  flr_loop_s       s;
  flr_loop_s       n;
  logic [1:0]      rst_pipe;
  logic            rst_n;
  logic [2:0][9:0] temp;
  logic [2:0][7:0] span;
  logic [2:0]      hold;
  logic [2:0][3:0] hyst;
  logic [7:0]      ramp_local;
  logic [7:0]      ramp_remote2;
  logic            wr_ok;

  // Reset enters asynchronously but is released on the clock.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= flr_pkg::RST_SYNC;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Channel 0 is remote one, 1 is local, 2 is remote two; fan N follows channel N-1.
  assign temp = {remote2_temp, local_temp, remote1_temp};
  assign span = {remote2_ramp_temperature_span, local_ramp_temperature_span, remote1_ramp_temperature_span};
  assign hold = {fan3_below_start_hold, fan2_below_start_hold, fan1_below_start_hold};
  assign hyst[0] = s.hyst_r1loc[flr_pkg::HYST_HI_LSB +: 4];
  assign hyst[1] = s.hyst_r1loc[flr_pkg::HYST_LO_LSB +: 4];
  assign hyst[2] = s.hyst_cpur2[flr_pkg::HYST_HI_LSB +: 4];

  function automatic logic [7:0] loop_duty(
    input logic [7:0] t,
    input logic [7:0] start,
    input logic [7:0] floor_duty,
    input logic [7:0] rise,
    input logic       running,
    input logic       hold_floor
  );
    logic [16:0] sum;
    sum = 17'h00000;
    if (t > start) begin
      sum = 17'(floor_duty) + 17'(8'(t - start)) * 17'(rise);
      return (sum > 17'(flr_pkg::DUTY_FULL)) ? flr_pkg::DUTY_FULL : sum[7:0];
    end else if (running) begin
      return floor_duty;
    end
    return hold_floor ? floor_duty : flr_pkg::DUTY_OFF;
  endfunction

  function automatic logic [7:0] read_reg(input flr_loop_s r, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      flr_pkg::ADDR_ACOUSTIC2:  d = r.acoustic;
      flr_pkg::ADDR_FLOOR1:     d = r.floor_duty[0];
      flr_pkg::ADDR_FLOOR2:     d = r.floor_duty[1];
      flr_pkg::ADDR_FLOOR3:     d = r.floor_duty[2];
      flr_pkg::ADDR_START_R1:   d = r.start[0];
      flr_pkg::ADDR_START_LOC:  d = r.start[1];
      flr_pkg::ADDR_START_R2:   d = r.start[2];
      flr_pkg::ADDR_CRIT_R1:    d = r.crit[0];
      flr_pkg::ADDR_CRIT_LOC:   d = r.crit[1];
      flr_pkg::ADDR_CRIT_R2:    d = r.crit[2];
      flr_pkg::ADDR_HYST_R1LOC: d = r.hyst_r1loc;
      flr_pkg::ADDR_HYST_CPUR2: d = r.hyst_cpur2;
      default:                  d = 8'h00;
    endcase
    return d;
  endfunction

  always_comb begin
    n     = s;
    wr_ok = reg_wr_en && !config_lock;
    if (wr_ok) begin
      unique case (reg_addr)
        flr_pkg::ADDR_ACOUSTIC2:  n.acoustic = reg_wdata;
        flr_pkg::ADDR_FLOOR1:     n.floor_duty[0] = auto_mode ? s.floor_duty[0] : reg_wdata;
        flr_pkg::ADDR_FLOOR2:     n.floor_duty[1] = auto_mode ? s.floor_duty[1] : reg_wdata;
        flr_pkg::ADDR_FLOOR3:     n.floor_duty[2] = auto_mode ? s.floor_duty[2] : reg_wdata;
        flr_pkg::ADDR_START_R1:   n.start[0] = reg_wdata;
        flr_pkg::ADDR_START_LOC:  n.start[1] = reg_wdata;
        flr_pkg::ADDR_START_R2:   n.start[2] = reg_wdata;
        flr_pkg::ADDR_CRIT_R1:    n.crit[0] = reg_wdata;
        flr_pkg::ADDR_CRIT_LOC:   n.crit[1] = reg_wdata;
        flr_pkg::ADDR_CRIT_R2:    n.crit[2] = reg_wdata;
        flr_pkg::ADDR_HYST_R1LOC: n.hyst_r1loc = reg_wdata;
        flr_pkg::ADDR_HYST_CPUR2: n.hyst_cpur2 = reg_wdata;
        default:                  n.acoustic = s.acoustic;
      endcase
    end
    n.rdata = read_reg(s, reg_rd_addr);
    n.ot_drive = 1'b0;
    for (int i = 0; i < 3; i++) begin
      // Start hysteresis: set above start, clear at start minus hysteresis.
      if (temp[i][9:2] > s.start[i]) begin
        n.running[i] = 1'b1;
      end else if (temp[i][9:2] <= flr_pkg::sat_sub(s.start[i], 8'(hyst[i]))) begin
        n.running[i] = 1'b0;
      end
      // A disabled limit never latches, so a stale latch clears at once.
      if (s.crit[i] == flr_pkg::CRIT_DISABLE) begin
        n.crit_on[i] = 1'b0;
      end else if (temp[i][9:2] > s.crit[i]) begin
        n.crit_on[i] = 1'b1;
      end else if (temp[i][9:2] < flr_pkg::sat_sub(s.crit[i], 8'(hyst[i]))) begin
        n.crit_on[i] = 1'b0;
      end
      if (s.crit[i] != flr_pkg::CRIT_DISABLE && temp[i] >= 10'({s.crit[i], 2'b00} + 10'h001)) begin
        n.ot_drive = overtemp_pin_is_output;
      end
      // In manual mode the floor register is the requested duty.
      n.target[i] = auto_mode ? loop_duty(temp[i][9:2], s.start[i], s.floor_duty[i], span[i],
                                          n.running[i], hold[i]) : s.floor_duty[i];
    end
    n.failsafe   = |n.crit_on;
    n.fan_out[0] = n.failsafe ? flr_pkg::DUTY_FULL : s.target[0];
    n.fan_out[1] = n.failsafe ? flr_pkg::DUTY_FULL : ramp_local;
    n.fan_out[2] = n.failsafe ? flr_pkg::DUTY_FULL : ramp_remote2;
    n.ot_level   = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s.acoustic   <= flr_pkg::RST_ACOUSTIC2;
      s.floor_duty <= {3{flr_pkg::RST_FLOOR}};
      s.start      <= {3{flr_pkg::RST_START}};
      s.crit       <= {3{flr_pkg::RST_CRIT}};
      s.hyst_r1loc <= flr_pkg::RST_HYST;
      s.hyst_cpur2 <= flr_pkg::RST_HYST;
      s.running    <= 3'h0;
      s.crit_on    <= 3'h0;
      s.target     <= {3{flr_pkg::DUTY_FULL}};
      s.fan_out    <= {3{flr_pkg::DUTY_FULL}};
      s.failsafe   <= 1'b0;
      s.ot_drive   <= 1'b0;
      s.ot_level   <= 1'b0;
      s.rdata      <= 8'h00;
    end else begin
      s <= n;
    end
  end

  // Smoothing only exists for the local and remote two loops.
  flr_ramp #(
    .TICK_FAST(TICK_FAST),
    .TICK_SLOW(TICK_SLOW)
  ) u_ramp_local (
    .clk         (clk),
    .rst_n       (rst_n),
    .smooth_en   (s.acoustic[flr_pkg::LOCAL_SMOOTH_BIT]),
    .rate_code   (s.acoustic[flr_pkg::LOCAL_RATE_LSB +: 3]),
    .slow_select (ramp_slow_select),
    .quarter_rate(local_quarter_rate),
    .target      (s.target[1]),
    .duty        (ramp_local)
  );

  flr_ramp #(
    .TICK_FAST(TICK_FAST),
    .TICK_SLOW(TICK_SLOW)
  ) u_ramp_remote2 (
    .clk         (clk),
    .rst_n       (rst_n),
    .smooth_en   (s.acoustic[flr_pkg::R2_SMOOTH_BIT]),
    .rate_code   (s.acoustic[flr_pkg::R2_RATE_LSB +: 3]),
    .slow_select (ramp_slow_select),
    .quarter_rate(remote2_quarter_rate),
    .target      (s.target[2]),
    .duty        (ramp_remote2)
  );

  assign reg_rdata            = s.rdata;
  assign fan1_duty            = s.fan_out[0];
  assign fan2_duty            = s.fan_out[1];
  assign fan3_duty            = s.fan_out[2];
  assign failsafe_active      = s.failsafe;
  assign overtemp_signal_o    = s.ot_level;
  assign overtemp_signal_oe_n = !s.ot_drive;

  AST_FAILSAFE_FULL: assert property (@(posedge clk) disable iff (!rst_n)
    failsafe_active |-> (fan1_duty == 8'hff && fan2_duty == 8'hff && fan3_duty == 8'hff))
    else $error("fail-safe active without full duty");

  AST_LOCK_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr_en && config_lock) |=> ($stable(s.start) && $stable(s.crit) && $stable(s.acoustic)
                                    && $stable(s.hyst_r1loc) && $stable(s.hyst_cpur2)))
    else $error("write took effect while locked");

  AST_FLOOR_AUTO: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr_en && auto_mode) |=> $stable(s.floor_duty))
    else $error("floor written in automatic mode");

  AST_CRIT_DISABLE: assert property (@(posedge clk) disable iff (!rst_n)
    (s.crit[1] == 8'h80) |=> !s.crit_on[1])
    else $error("disabled limit latched the fail-safe");

  AST_CRIT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (s.crit_on[1] && s.crit[1] != 8'h80 && local_temp[9:2] >= 8'(s.crit[1] - 8'(hyst[1])))
    |=> s.crit_on[1])
    else $error("fail-safe released inside hysteresis");

  AST_OT_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    (overtemp_pin_is_output && s.crit[1] != 8'h80 && local_temp > {s.crit[1], 2'b00})
    |=> (!overtemp_signal_oe_n && !overtemp_signal_o))
    else $error("overtemperature pin not driven low");

  AST_REG_RESET_START: assert property (@(posedge clk)
    $rose(rst_n) |-> (s.start[0] == 8'h5a && s.start[2] == 8'h5a && s.hyst_r1loc == 8'h44))
    else $error("start or hysteresis reset value wrong");

  AST_IDLE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (auto_mode && !s.running[0] && !fan1_below_start_hold && remote1_temp[9:2] <= s.start[0])
    |=> (s.target[0] == 8'h00))
    else $error("idle fan not switched off");

  // The pin stays released whenever it is configured as an input.
  AST_OT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    !overtemp_pin_is_output |=> overtemp_signal_oe_n)
    else $error("overtemperature pin driven while configured as input");

  AST_FLOOR_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
    !auto_mode |=> s.target[0] == $past(s.floor_duty[0]))
    else $error("manual target did not follow floor register");

  AST_RUN_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (remote1_temp[9:2] > s.start[0]) |=> s.running[0])
    else $error("loop not running above start temperature");

  // Checks the local channel against the low nibble directly, not the decoded copy.
  AST_RUN_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (local_temp[9:2] <= flr_pkg::sat_sub(s.start[1], 8'(s.hyst_r1loc[3:0]))) |=> !s.running[1])
    else $error("loop still running below start minus hysteresis");

endmodule
`default_nettype wire

// [dv/flr_fan_model.sv]
`timescale 1ns/10ps
`default_nettype none
module flr_fan_model (
  // Clock and window control
  input  wire logic       clk,
  input  wire logic       clear,
  // Drive from the fan loop
  input  wire logic [7:0] duty,
  // Largest one-cycle change of drive seen since the last clear
  output logic      [7:0] max_delta
);
  logic [7:0] last;
  logic [7:0] delta;

  // A real fan only sees the drive level, so the model just records how hard the drive jumps.
  assign delta = (duty > last) ? 8'(duty - last) : 8'(last - duty);

  always_ff @(posedge clk) begin
    last <= duty;
    if (clear) begin
      max_delta <= 8'h00;
    end else if (delta > max_delta) begin
      max_delta <= delta;
    end
  end
endmodule
`default_nettype wire

// [dv/fan_loop_limits_and_ramp_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module fan_loop_limits_and_ramp_tb;
  logic       clk, resetn, reg_wr_en, config_lock, auto_mode, slow_sel, quarter_l, quarter_r2;
  logic       hold1, hold2, hold3, pin_out, model_clear, failsafe_active, ot_o, ot_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rd_addr, reg_rdata, span1, span2, span3;
  logic [7:0] fan1_duty, fan2_duty, fan3_duty, delta2, delta3;
  logic [9:0] t_r1, t_loc, t_r2;
  int         n_errors;
  int         comparisons;

  flr_fan_loop #(.TICK_FAST(8), .TICK_SLOW(12)) flr_fan_loop_inst (
    .clk(clk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rd_addr(reg_rd_addr), .reg_rdata(reg_rdata), .config_lock(config_lock), .auto_mode(auto_mode),
    .ramp_slow_select(slow_sel), .local_quarter_rate(quarter_l), .remote2_quarter_rate(quarter_r2),
    .fan1_below_start_hold(hold1), .fan2_below_start_hold(hold2), .fan3_below_start_hold(hold3),
    .overtemp_pin_is_output(pin_out), .remote1_temp(t_r1), .local_temp(t_loc), .remote2_temp(t_r2),
    .remote1_ramp_temperature_span(span1), .local_ramp_temperature_span(span2),
    .remote2_ramp_temperature_span(span3), .fan1_duty(fan1_duty), .fan2_duty(fan2_duty),
    .fan3_duty(fan3_duty), .failsafe_active(failsafe_active), .overtemp_signal_o(ot_o),
    .overtemp_signal_oe_n(ot_oe_n));

  flr_fan_model fan2_model (.clk(clk), .clear(model_clear), .duty(fan2_duty), .max_delta(delta2));
  flr_fan_model fan3_model (.clk(clk), .clear(model_clear), .duty(fan3_duty), .max_delta(delta3));

  always #4 clk = ~clk;

  task automatic stop_test();
    $display("Checks made %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1 reg_rd_addr = a;
    cyc(2);
    chk($sformatf("register %h", a), exp, reg_rdata);
  endtask

  task automatic t_reset();
    logic [7:0] rst_val [12] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a,
                                 8'h64, 8'h64, 8'h64, 8'h44, 8'h44};
    for (int i = 0; i < 12; i++) begin
      rd_chk(8'(8'h63 + i), rst_val[i]);
    end
    rd_chk(8'h6f, 8'h00);
    chk("failsafe after reset", 8'h00, {7'h00, failsafe_active});
    $display("Test reset values done");
  endtask

  task automatic t_access();
    logic [7:0] duty_set [4] = '{8'h00, 8'h40, 8'h80, 8'hff};
    wr(8'h68, 8'h30);
    rd_chk(8'h68, 8'h30);
    wr(8'h68, 8'h5a);
    auto_mode = 1'b1;
    wr(8'h64, 8'h11);
    rd_chk(8'h64, 8'h80);
    auto_mode = 1'b0;
    config_lock = 1'b1;
    wr(8'h6b, 8'h70);
    wr(8'h63, 8'hff);
    wr(8'h65, 8'h01);
    rd_chk(8'h6b, 8'h64);
    rd_chk(8'h63, 8'h00);
    rd_chk(8'h65, 8'h80);
    config_lock = 1'b0;
    foreach (duty_set[i]) begin
      wr(8'h64, duty_set[i]);
      cyc(4);
      chk("manual fan1 duty", duty_set[i], fan1_duty);
    end
    $display("Test register access done");
  endtask

  task automatic t_ramp(input bit r2, input logic [2:0] code, input bit slow, input bit quarter);
    int         steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};
    int         tick;
    int         drop;
    logic [7:0] floor_addr;
    tick = (slow ? 12 : 8) * (quarter ? 4 : 1);
    floor_addr = r2 ? 8'h66 : 8'h65;
    wr(8'h63, 8'h00);
    wr(floor_addr, 8'hff);
    cyc(4);
    chk("unsmoothed jump", 8'hff, r2 ? fan3_duty : fan2_duty);
    slow_sel = slow;
    quarter_l = quarter & ~r2;
    quarter_r2 = quarter & r2;
    wr(8'h63, r2 ? {1'b1, code, 4'h0} : {4'h0, 1'b1, code});
    model_clear = 1'b1;
    cyc(1);
    model_clear = 1'b0;
    wr(floor_addr, 8'h00);
    cyc(3 * tick);
    drop = 255 - int'(r2 ? fan3_duty : fan2_duty);
    comparisons++;
    if (drop < 2 * steps[code] || drop > 4 * steps[code]) begin
      n_errors++;
      $display("[FAIL] ramp drop expected near %0d seen %0d", 3 * steps[code], drop);
    end
    chk("ramp step size", 8'(steps[code]), r2 ? delta3 : delta2);
    slow_sel = 1'b0;
    quarter_l = 1'b0;
    quarter_r2 = 1'b0;
    $display("Test ramp channel %0d code %0d slow %0d quarter %0d done", r2, code, slow, quarter);
  endtask

  task automatic t_auto();
    wr(8'h63, 8'h00);
    wr(8'h65, 8'h80);
    wr(8'h6d, 8'h02);
    auto_mode = 1'b1;
    t_loc = 10'(95 << 2);
    cyc(6);
    chk("fan2 above start", 8'h94, fan2_duty);
    t_loc = 10'(89 << 2);
    cyc(6);
    chk("fan2 inside hysteresis", 8'h80, fan2_duty);
    t_loc = 10'(88 << 2);
    cyc(6);
    chk("fan2 below band off", 8'h00, fan2_duty);
    hold2 = 1'b1;
    cyc(6);
    chk("fan2 below band hold", 8'h80, fan2_duty);
    $display("Test automatic loop done");
  endtask

  task automatic t_crit();
    wr(8'h6d, 8'h04);
    pin_out = 1'b1;
    t_loc = 10'(101 << 2);
    cyc(4);
    chk("failsafe on", 8'h01, {7'h00, failsafe_active});
    chk("fan1 full", 8'hff, fan1_duty);
    chk("fan3 full", 8'hff, fan3_duty);
    chk("pin enable", 8'h00, {7'h00, ot_oe_n});
    chk("pin level", 8'h00, {7'h00, ot_o});
    t_loc = 10'(97 << 2);
    cyc(6);
    chk("fan2 still full", 8'hff, fan2_duty);
    t_loc = 10'(95 << 2);
    cyc(6);
    chk("fan2 released", 8'h94, fan2_duty);
    t_loc = 10'((100 << 2) + 1);
    cyc(4);
    chk("pin quarter excess", 8'h00, {7'h00, ot_oe_n});
    chk("no failsafe at limit", 8'h00, {7'h00, failsafe_active});
    t_loc = 10'(100 << 2);
    cyc(4);
    chk("pin at limit", 8'h01, {7'h00, ot_oe_n});
    wr(8'h6b, 8'h80);
    t_loc = 10'(110 << 2);
    cyc(4);
    chk("failsafe disabled", 8'h00, {7'h00, failsafe_active});
    chk("pin disabled", 8'h01, {7'h00, ot_oe_n});
    $display("Test critical limit done");
  endtask

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {reg_wr_en, config_lock, auto_mode, slow_sel, quarter_l, quarter_r2} = 6'h00;
    {hold1, hold2, hold3, pin_out, model_clear} = 5'h00;
    {reg_addr, reg_wdata, reg_rd_addr} = 24'h00_0000;
    {span1, span2, span3} = 24'h04_0404;
    t_r1 = 10'(20 << 2);
    t_loc = 10'(20 << 2);
    t_r2 = 10'(20 << 2);
    n_errors = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    cyc(4);
    t_reset();
    t_access();
    for (int c = 0; c < 8; c++) begin
      t_ramp(1'b0, 3'(c), 1'b0, 1'b0);
    end
    t_ramp(1'b1, 3'h3, 1'b0, 1'b0);
    t_ramp(1'b1, 3'h5, 1'b1, 1'b0);
    t_ramp(1'b0, 3'h2, 1'b0, 1'b1);
    t_auto();
    t_crit();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    $display("[FAIL] run limit expected end seen hang");
    stop_test();
  end
endmodule
`default_nettype wire
